// ==== rtl/dba_alloc_top.sv ====
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module dba_alloc_top (
   input wire logic CLK,                                 // Display clock, 40 MHz
   input wire logic RST_N,                               // Asynchronous reset, active low
   input wire logic PSEL,                                // APB select
   input wire logic PENABLE,                             // APB access phase
   input wire logic PWRITE,                              // APB direction
   input wire logic [11:0] PADDR,                        // APB byte address
   input wire logic [31:0] PWDATA,                       // APB write data
   output logic [31:0] PRDATA,                           // APB read data
   output logic PREADY,                                  // APB ready
   output logic PSLVERR,                                 // APB error, unmapped address
   input wire logic VBLANK,                              // Pipe vertical blank level
   input wire logic [dba_pkg::NUM_PLANES-1:0] FETCH_REQ, // Per-plane fetch requests
   output dba_pkg::dba_fetch_type [dba_pkg::NUM_PLANES-1:0] FETCH_GRANT, // Per-plane grants
   output logic [dba_pkg::NUM_PLANES-1:0] BLEND_EN,      // Plane takes part in blending
   output logic [dba_pkg::NUM_PLANES-1:0] HDR_OUT,       // Plane delivers wide-precision output
   output logic [2*dba_pkg::NUM_PLANES-1:0] WM_EN,       // Watermark level enables, two per plane
   output logic CURSOR_ON                                // Active cursor enabled
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      dba_pkg::dba_plane_type [dba_pkg::NUM_PLANES-1:0] pend; // Software copies
      dba_pkg::dba_plane_type [dba_pkg::NUM_PLANES-1:0] act;  // Copies the pipe uses
      logic [dba_pkg::NUM_PLANES-1:0] arm;               // Surface base written, update pending
      logic [dba_pkg::NUM_PLANES-1:0] buf_arm;           // Range written, update pending
      logic [dba_pkg::NUM_PLANES-1:0] restart;           // Range just latched
      logic [31:0] cfg;                                  // Pipe configuration
      logic [31:0] cursor_control_reg;                              // Cursor control, pending
      logic [31:0] cur_comp;                             // Cursor compression, pending
      logic [31:0] cursor_surface_base;                             // Cursor surface base
      logic [31:0] cursor_control_reg_act;                          // Cursor control, active
      logic [31:0] cur_comp_act;                         // Cursor compression, active
      logic cur_arm;                                     // Cursor update pending
      dba_pkg::dba_apb_state_type apb;                   // Bus phase
      logic [31:0] prdata;                               // Read data register
      logic pslverr;                                     // Error register
      logic [dba_pkg::NUM_PLANES-1:0] blend;             // Blend enables
      logic [dba_pkg::NUM_PLANES-1:0] hdr_out;           // Wide-output enables
      logic [2*dba_pkg::NUM_PLANES-1:0] wm_en;           // Watermark enables
      logic cur_on;                                      // Cursor enable
   } dba_state_type;

   dba_state_type s_q;                                   // Registered state
   dba_state_type s_d;                                   // Next state
   logic [dba_pkg::NUM_PLANES-1:0] range_ok;             // Active range legal for fetch

   // ************************************************************
   // Fetch pointers, one per plane
   // ************************************************************
   genvar gp;
   generate
      for (gp = 0; gp < dba_pkg::NUM_PLANES; gp++) begin : g_plane
         logic [dba_pkg::BLK_W-1:0] first_blk;           // Active start block
         logic [dba_pkg::BLK_W-1:0] last_blk;            // Active end block
         assign first_blk = s_q.act[gp].buf_cfg[dba_pkg::BUF_START_LSB +: dba_pkg::BLK_W];
         assign last_blk = s_q.act[gp].buf_cfg[dba_pkg::BUF_END_LSB +: dba_pkg::BLK_W];
         // Empty ranges, and ranges into an unpowered second slice, never fetch
         assign range_ok[gp] = (first_blk <= last_blk) &&
            (s_q.cfg[dba_pkg::CFG_SLICE_TWO] || (last_blk < dba_pkg::SLICE_TWO_FIRST));
         dba_fetch_ptr u_ptr (
            .clk(CLK),
            .rst_n(RST_N),
            .go(range_ok[gp] && s_q.act[gp].ctl[dba_pkg::CTL_ENABLE] && s_q.cfg[dba_pkg::CFG_PIPE_ON]),
            .restart(s_q.restart[gp]),
            .req(FETCH_REQ[gp]),
            .first_blk(first_blk),
            .last_blk(last_blk),
            .grant(FETCH_GRANT[gp])
         );
      end
   endgenerate

   // ************************************************************
   // Next-state logic
   // ************************************************************
   always_comb begin
      logic pipe_on;                                     // Pipe running
      logic hdr;                                         // Wide-range mode
      logic xfer;                                        // Completing APB transfer
      logic plane_hit;                                   // Address in a plane block
      logic [1:0] pidx;                                  // Addressed plane
      logic [2:0] preg;                                  // Addressed plane register
      logic mapped;                                      // Address decodes
      logic [31:0] rdata;                                // Read mux
      logic en;                                          // Active plane enable
      pipe_on = s_q.cfg[dba_pkg::CFG_PIPE_ON];
      hdr = s_q.cfg[dba_pkg::CFG_HDR_MODE];
      xfer = PSEL && PENABLE && (s_q.apb == dba_pkg::DBA_ST_DONE);
      plane_hit = (PADDR[11:8] == dba_pkg::PLANE_PAGE) && !PADDR[7] && (PADDR[1:0] == 2'h0);
      pidx = PADDR[6:5];
      preg = PADDR[4:2];
      mapped = 1'b0;
      rdata = dba_pkg::REG_RESET;
      en = 1'b0;
      s_d = s_q;
      s_d.restart = '0;

      // Read decode; plane registers read back their pending copies, +0x14 the active range
      if (plane_hit) begin
         mapped = 1'b1;
         unique case (preg)
            dba_pkg::PREG_CTL: rdata = s_q.pend[pidx].ctl;
            dba_pkg::PREG_SURF: rdata = s_q.pend[pidx].surf;
            dba_pkg::PREG_BUF: rdata = s_q.pend[pidx].buf_cfg;
            dba_pkg::PREG_WM0: rdata = s_q.pend[pidx].wm0;
            dba_pkg::PREG_WM1: rdata = s_q.pend[pidx].wm1;
            dba_pkg::PREG_ACT_BUF: rdata = s_q.act[pidx].buf_cfg;
            default: mapped = 1'b0;              // Offsets 0x18, 0x1C unmapped
         endcase
      end else begin
         mapped = 1'b1;
         unique case (PADDR)
            dba_pkg::OFS_PIPE_CFG: rdata = s_q.cfg;
            dba_pkg::OFS_STATUS: rdata = {19'h0, s_q.cur_arm, s_q.buf_arm, s_q.arm, s_q.blend};
            dba_pkg::OFS_CURSOR_CONTROL_REG: rdata = s_q.cursor_control_reg;
            dba_pkg::OFS_CUR_COMP: rdata = s_q.cur_comp;
            dba_pkg::OFS_CURSOR_SURFACE_BASE: rdata = s_q.cursor_surface_base;
            default: mapped = 1'b0;
         endcase
      end

      // Bus phases: one wait state, then PREADY with data and error
      if (s_q.apb == dba_pkg::DBA_ST_IDLE) begin
         if (PSEL && PENABLE) begin
            s_d.apb = dba_pkg::DBA_ST_DONE;
            s_d.prdata = PWRITE ? dba_pkg::REG_RESET : rdata;
            s_d.pslverr = !mapped;
         end
      end else begin
         s_d.apb = dba_pkg::DBA_ST_IDLE;
         s_d.prdata = dba_pkg::REG_RESET;
         s_d.pslverr = 1'b0;
      end

      // Latch pending copies; a write in the same cycle still re-arms below
      for (int p = 0; p < dba_pkg::NUM_PLANES; p++) begin
         if (s_q.arm[p] && (VBLANK || !pipe_on || !s_q.act[p].ctl[dba_pkg::CTL_ENABLE])) begin
            s_d.act[p].ctl = s_q.pend[p].ctl;
            s_d.act[p].surf = s_q.pend[p].surf;
            s_d.act[p].wm0 = s_q.pend[p].wm0;
            s_d.act[p].wm1 = s_q.pend[p].wm1;
            s_d.arm[p] = 1'b0;
         end
         // Range swaps only at blank, or at once while the pipe is off, so software can order shrink before grow
         if (s_q.buf_arm[p] && (VBLANK || !pipe_on)) begin
            s_d.act[p].buf_cfg = s_q.pend[p].buf_cfg;
            s_d.buf_arm[p] = 1'b0;
            s_d.restart[p] = 1'b1;
         end
      end
      if (s_q.cur_arm && (VBLANK || !pipe_on || !s_q.cursor_control_reg_act[dba_pkg::CTL_ENABLE])) begin
         s_d.cursor_control_reg_act = s_q.cursor_control_reg;
         s_d.cur_comp_act = s_q.cur_comp;
         s_d.cur_arm = 1'b0;
      end

      // Writes take effect at the completing edge only
      if (xfer && PWRITE && mapped) begin
         if (plane_hit) begin
            unique case (preg)
               dba_pkg::PREG_CTL: s_d.pend[pidx].ctl = PWDATA;
               dba_pkg::PREG_SURF: begin
                  s_d.pend[pidx].surf = PWDATA;
                  s_d.arm[pidx] = 1'b1;
               end
               dba_pkg::PREG_BUF: begin
                  s_d.pend[pidx].buf_cfg = PWDATA;
                  s_d.buf_arm[pidx] = 1'b1;
               end
               dba_pkg::PREG_WM0: s_d.pend[pidx].wm0 = PWDATA;
               dba_pkg::PREG_WM1: s_d.pend[pidx].wm1 = PWDATA;
               default: ;                        // Active range is read only
            endcase
         end else begin
            unique case (PADDR)
               dba_pkg::OFS_PIPE_CFG: s_d.cfg = PWDATA & dba_pkg::CFG_MASK;
               dba_pkg::OFS_CURSOR_CONTROL_REG: s_d.cursor_control_reg = PWDATA;
               dba_pkg::OFS_CUR_COMP: s_d.cur_comp = PWDATA;
               dba_pkg::OFS_CURSOR_SURFACE_BASE: begin
                  s_d.cursor_surface_base = PWDATA;
                  s_d.cur_arm = 1'b1;
               end
               default: ;                        // Status is read only
            endcase
         end
      end

      // Plane outputs from the active copies
      for (int p = 0; p < dba_pkg::NUM_PLANES; p++) begin
         en = s_q.act[p].ctl[dba_pkg::CTL_ENABLE] && pipe_on;
         // In wide-range mode the standard planes drop out of blending
         s_d.blend[p] = en && (!hdr || dba_pkg::HDR_PLANE_MASK[p]);
         s_d.hdr_out[p] = en && hdr && dba_pkg::HDR_PLANE_MASK[p];
         // Cleared enable bit keeps the level off
         s_d.wm_en[2*p] = en && s_q.act[p].wm0[dba_pkg::WM_ENABLE];
         s_d.wm_en[2*p+1] = en && s_q.act[p].wm1[dba_pkg::WM_ENABLE];
      end
      s_d.cur_on = pipe_on && s_q.cursor_control_reg_act[dba_pkg::CTL_ENABLE];
   end

   // Register the state
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_q <= '0;
         s_q.apb <= dba_pkg::DBA_ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************************************
   // Outputs, all straight from flip-flops
   // ************************************************************
   assign PRDATA = s_q.prdata;
   assign PREADY = s_q.apb[1];
   assign PSLVERR = s_q.pslverr;
   assign BLEND_EN = s_q.blend;
   assign HDR_OUT = s_q.hdr_out;
   assign WM_EN = s_q.wm_en;
   assign CURSOR_ON = s_q.cur_on;

endmodule : dba_alloc_top

// ==== rtl/dba_fetch_ptr.sv ====
`timescale 1ns/1ps
// Walks one plane's fill pointer over its active block range, eight lines per block
module dba_fetch_ptr (
   input wire logic clk,                                 // Display clock
   input wire logic rst_n,                               // Asynchronous reset, active low
   input wire logic go,                                  // Plane active and range legal
   input wire logic restart,                             // New active range just latched
   input wire logic req,                                 // Fetch request pulse
   input wire logic [dba_pkg::BLK_W-1:0] first_blk,      // Active start block
   input wire logic [dba_pkg::BLK_W-1:0] last_blk,       // Active end block
   output dba_pkg::dba_fetch_type grant                  // Registered grant
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [dba_pkg::BLK_W-1:0] ptr_blk;                // Next block to fill
      logic [2:0] ptr_line;                              // Next line in that block
      dba_pkg::dba_fetch_type out;                       // Grant shown at the port
   } dba_ptr_state_type;

   dba_ptr_state_type s_q;                               // Registered state
   dba_ptr_state_type s_d;                               // Next state

   // Pointer holds a block inside [first_blk, last_blk] whenever a grant is issued from it
   always_comb begin
      s_d = s_q;
      s_d.out.valid = 1'b0;
      if (!go || restart) begin
         // Parked at the range start; no fill outside the range
         s_d.ptr_blk = first_blk;
         s_d.ptr_line = 3'h0;
      end else if (req) begin
         s_d.out.valid = 1'b1;
         s_d.out.blk = s_q.ptr_blk;
         s_d.out.line = s_q.ptr_line;
         if (s_q.ptr_line == dba_pkg::LINES_PER_BLOCK_LAST) begin
            // Block full after its eighth line
            s_d.ptr_line = 3'h0;
            // Wrap to the start rather than step past the end
            if (s_q.ptr_blk == last_blk) begin
               s_d.ptr_blk = first_blk;
            end else begin
               s_d.ptr_blk = s_q.ptr_blk + 11'h001;
            end
         end else begin
            s_d.ptr_line = s_q.ptr_line + 3'h1;
         end
      end
   end

   // Register the state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign grant = s_q.out;

endmodule : dba_fetch_ptr

// ==== rtl/dba_pkg.sv ====
package dba_pkg;

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int NUM_PLANES = 4;                           // Universal planes 1..4 of one pipe
   localparam int BLK_W = 11;                               // Block index width, 0..2047
   localparam logic [BLK_W-1:0] SLICE_TWO_FIRST = 11'h400;  // First block of slice two (1024)
   localparam logic [BLK_W-1:0] BUFFER_LAST = 11'h7FF;      // Last block of the buffer (2047)
   localparam logic [2:0] LINES_PER_BLOCK_LAST = 3'h7;      // Eight cache lines per block
   localparam logic [NUM_PLANES-1:0] HDR_PLANE_MASK = 4'h7; // Planes 1..3 carry wide precision

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [11:0] OFS_PIPE_CFG = 12'h000;     // Pipe configuration
   localparam logic [11:0] OFS_STATUS = 12'h004;       // Pending and active state, read only
   localparam logic [11:0] OFS_CURSOR_CONTROL_REG = 12'h080;      // cursor_control_reg, pending copy
   localparam logic [11:0] OFS_CUR_COMP = 12'h084;     // cursor_compress_ctrl, pending copy
   localparam logic [11:0] OFS_CURSOR_SURFACE_BASE = 12'h088;     // cursor_surface_base, arms the update
   localparam logic [11:0] OFS_PLANE_BASE = 12'h100;   // Plane 1 block, planes every 0x20
   localparam logic [3:0] PLANE_PAGE = 4'h1;           // PADDR[11:8] of the plane blocks
   localparam logic [2:0] PREG_CTL = 3'h0;             // +0x00 plane control
   localparam logic [2:0] PREG_SURF = 3'h1;            // +0x04 plane_surface_base
   localparam logic [2:0] PREG_BUF = 3'h2;             // +0x08 buffer range
   localparam logic [2:0] PREG_WM0 = 3'h3;             // +0x0C plane_watermark level 0
   localparam logic [2:0] PREG_WM1 = 3'h4;             // +0x10 plane_watermark level 1
   localparam logic [2:0] PREG_ACT_BUF = 3'h5;         // +0x14 active buffer range, read only

   // ************************************************************
   // Fields and reset values
   // ************************************************************
   localparam int CFG_PIPE_ON = 0;                      // Pipe running
   localparam int CFG_HDR_MODE = 1;                     // Wide-range blending mode
   localparam int CFG_SLICE_TWO = 2;                    // buffer_slice_two powered
   localparam logic [31:0] CFG_MASK = 32'h0000_0007;    // Writable configuration bits
   localparam int CTL_ENABLE = 31;                      // Plane or cursor enable
   localparam int WM_ENABLE = 31;                       // Watermark level enable
   localparam int BUF_START_LSB = 0;                    // Start block, lower half
   localparam int BUF_END_LSB = 16;                     // End block, upper half
   localparam logic [31:0] REG_RESET = 32'h0000_0000;   // Every register resets to zero

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      DBA_ST_IDLE = 2'h1,                                // Waiting for an access phase
      DBA_ST_DONE = 2'h2                                 // PREADY high, transfer completes
   } dba_apb_state_type;

   typedef struct packed {
      logic [31:0] ctl;                                  // Plane control
      logic [31:0] surf;                                 // Surface base
      logic [31:0] buf_cfg;                              // End and start block
      logic [31:0] wm0;                                  // Watermark level 0
      logic [31:0] wm1;                                  // Watermark level 1
   } dba_plane_type;

   typedef struct packed {
      logic valid;                                       // One-cycle fetch grant
      logic [BLK_W-1:0] blk;                             // Block being filled
      logic [2:0] line;                                  // Cache line inside the block
   } dba_fetch_type;

endpackage : dba_pkg

// ==== verification/dba_alloc_properties.sv ====
`timescale 1ns/1ps
// ************************************************************
// Port checks of the buffer allocation block
// ************************************************************
module dba_alloc_properties (
   input wire logic CLK, // Display clock
   input wire logic RST_N, // Reset, active low
   input wire logic PSEL, // APB select
   input wire logic PENABLE, // APB access phase
   input wire logic [31:0] PRDATA, // APB read data
   input wire logic PREADY, // APB ready
   input wire logic PSLVERR, // APB error
   input wire logic [3:0] FETCH_REQ, // Fetch requests
   input wire dba_pkg::dba_fetch_type [3:0] FETCH_GRANT, // Fetch grants
   input wire logic [3:0] BLEND_EN, // Blend enables
   input wire logic [3:0] HDR_OUT // Wide output enables
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Exactly one wait state, answer stands one cycle
   a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("ready late");
   a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
   a_err_pairs: assert property (PSLVERR |-> PREADY) else $error("error without ready");
   // Idle read bus is zero so stale data never leaks
   a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0000_0000) else $error("read data idle");
   a_hdr_planes: assert property ((HDR_OUT & ~dba_pkg::HDR_PLANE_MASK) == 4'h0)
      else $error("wide output on standard plane");
   a_hdr_bypass: assert property (|HDR_OUT |-> !BLEND_EN[3] && (HDR_OUT & ~BLEND_EN) == 4'h0)
      else $error("blend set wrong in wide mode");
   a_grant_cause: assert property (FETCH_GRANT[0].valid |-> $past(FETCH_REQ[0]))
      else $error("grant without request");
   a_line_step: assert property ($past(FETCH_GRANT[0].valid) && FETCH_GRANT[0].valid &&
      $past(FETCH_GRANT[0].line) != 3'h7 |-> FETCH_GRANT[0].blk == $past(FETCH_GRANT[0].blk) &&
      FETCH_GRANT[0].line == $past(FETCH_GRANT[0].line) + 3'h1) else $error("line step wrong");
   a_line_wrap: assert property ($past(FETCH_GRANT[0].valid) && FETCH_GRANT[0].valid &&
      $past(FETCH_GRANT[0].line) == 3'h7 |-> FETCH_GRANT[0].line == 3'h0) else $error("line wrap wrong");
endmodule : dba_alloc_properties

bind dba_alloc_top dba_alloc_properties u_props (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FETCH_REQ(FETCH_REQ), .FETCH_GRANT(FETCH_GRANT),
   .BLEND_EN(BLEND_EN), .HDR_OUT(HDR_OUT));

// ==== verification/tb_display_buffer_allocation.sv ====
`timescale 1ns/1ps
// ************************************************************
// Self-checking bench of the buffer allocation block
// ************************************************************
module tb_display_buffer_allocation;
   logic CLK = 1'b0; // Display clock, 25 ns
   logic RST_N = 1'b0; // Reset, active low
   logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, VBLANK = 1'b0; // Bus and blank
   logic [11:0] PADDR = 12'h000; // Bus address
   logic [31:0] PWDATA = 32'h0, PRDATA; // Bus data
   logic PREADY, PSLVERR, CURSOR_ON; // Design answers
   logic [3:0] FETCH_REQ = 4'h0, BLEND_EN, HDR_OUT; // Plane fetch and blend
   logic [7:0] WM_EN; // Watermark enables
   dba_pkg::dba_fetch_type [3:0] FETCH_GRANT; // Grants
   int err_total = 0, n_tests = 0, cyc = 0; // Counters
   logic [31:0] rd_q; // Last read word
   logic err_q; // Last error flag
   always #12.5 CLK = ~CLK;
   dba_alloc_top uut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .VBLANK(VBLANK), .FETCH_REQ(FETCH_REQ), .FETCH_GRANT(FETCH_GRANT), .BLEND_EN(BLEND_EN),
      .HDR_OUT(HDR_OUT), .WM_EN(WM_EN), .CURSOR_ON(CURSOR_ON));
   task chk(input bit ok, input string msg);
      n_tests++;
      if (!ok) begin
         err_total++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask : chk
   // One APB transfer; the master waits for PREADY, the timeout bounds the wait
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      rd_q = PRDATA;
      err_q = PSLVERR;
      PSEL <= 1'b0; PENABLE <= 1'b0;
   endtask : apb
   task rd(input logic [11:0] a, input logic [31:0] exp, input string msg);
      apb(1'b0, a, 32'h0);
      chk(rd_q === exp && err_q === 1'b0, msg);
   endtask : rd
   // Let a latch and the registered outputs land
   task settle();
      repeat (3) @(posedge CLK);
      #1;
   endtask : settle
   task vblank();
      @(posedge CLK) VBLANK <= 1'b1;
      @(posedge CLK) VBLANK <= 1'b0;
      settle();
   endtask : vblank
   // Reset values and an unmapped address
   task t_reset();
      chk(PREADY === 1'b0 && BLEND_EN === 4'h0 && WM_EN === 8'h00 && CURSOR_ON === 1'b0, "reset outputs");
      rd(12'h10C, 32'h0000_0000, "wm reset");
      apb(1'b1, 12'hFFC, 32'h1234_5678);
      chk(err_q === 1'b1, "unmapped write");
      apb(1'b0, 12'hFFC, 32'h0);
      chk(err_q === 1'b1 && rd_q === 32'h0, "unmapped read");
   endtask : t_reset
   // Range takes effect only at blank while the pipe runs
   task t_range();
      apb(1'b1, 12'h000, 32'h0000_0001);
      apb(1'b1, 12'h108, 32'h009F_0000);
      settle();
      rd(12'h114, 32'h0000_0000, "range early");
      vblank();
      rd(12'h114, 32'h009F_0000, "range at blank");
   endtask : t_range
   // Control and watermarks move with the surface write
   task t_atomic();
      apb(1'b1, 12'h100, 32'h8000_0000);
      apb(1'b1, 12'h10C, 32'h8000_80A0);
      apb(1'b1, 12'h104, 32'h0000_1000);
      settle();
      chk(BLEND_EN[0] === 1'b1 && WM_EN[1:0] === 2'b01, "disabled plane latch");
      apb(1'b1, 12'h110, 32'h8000_0000);
      apb(1'b1, 12'h104, 32'h0000_2000);
      settle();
      chk(WM_EN[1:0] === 2'b01, "level one early");
      vblank();
      chk(WM_EN[1:0] === 2'b11, "level one at blank");
   endtask : t_atomic
   // Lines walk eight per block and wrap over the range
   task t_fetch();
      apb(1'b1, 12'h108, 32'h0006_0005);
      vblank();
      @(posedge CLK) FETCH_REQ <= 4'h1;
      for (int i = 0; i < 17; i++) begin
         @(posedge CLK);
         #1;
         chk(FETCH_GRANT[0].valid === 1'b1 && FETCH_GRANT[0].blk === 11'(5 + (i / 8) % 2) &&
            FETCH_GRANT[0].line === 3'(i % 8), "grant walk");
      end
      @(posedge CLK) FETCH_REQ <= 4'h0;
   endtask : t_fetch
   // Wide mode drops plane four from blending
   task t_hdr();
      apb(1'b1, 12'h160, 32'h8000_0000);
      apb(1'b1, 12'h164, 32'h0000_3000);
      settle();
      chk(BLEND_EN === 4'h9 && HDR_OUT === 4'h0, "standard mode");
      apb(1'b1, 12'h000, 32'h0000_0003);
      settle();
      chk(BLEND_EN === 4'h1 && HDR_OUT === 4'h1, "wide mode");
   endtask : t_hdr
   // Cursor copies latch at once when off, else at blank
   task t_cursor();
      apb(1'b1, 12'h080, 32'h8000_0000);
      apb(1'b1, 12'h088, 32'h0000_4000);
      settle();
      chk(CURSOR_ON === 1'b1, "cursor first latch");
      apb(1'b1, 12'h080, 32'h0000_0000);
      apb(1'b1, 12'h088, 32'h0000_5000);
      settle();
      chk(CURSOR_ON === 1'b1, "cursor early");
      vblank();
      chk(CURSOR_ON === 1'b0, "cursor at blank");
   endtask : t_cursor
   // Data-rate sizing of planes one and four, then fetch gated by slice power
   task t_share();
      int avail;
      int rate0;
      int rate3;
      int sh0;
      int sh3;
      avail = 2048 - 8;
      rate0 = 100 * 100 * 4;
      rate3 = 10 * 1 * 4;
      sh3 = (avail * rate3) / (rate0 + rate3);
      if (sh3 < 8) begin
         // Below the minimum: raise, lock and take it from the pool
         sh3 = 8;
         avail = avail - sh3;
      end
      sh0 = (avail * rate0) / rate0;
      // Plane four moves clear of plane one's new range before plane one grows
      apb(1'b1, 12'h168, 32'(((avail + sh3 - 1) << 16) | avail));
      vblank();
      apb(1'b1, 12'h108, 32'((sh0 - 1) << 16));
      vblank();
      rd(12'h174, 32'h07F7_07F0, "share four");
      rd(12'h114, 32'h07EF_0000, "share one");
      // Slice two still unpowered, so plane four must not fetch
      @(posedge CLK) FETCH_REQ <= 4'h8;
      @(posedge CLK);
      @(posedge CLK) FETCH_REQ <= 4'h0;
      #1;
      chk(FETCH_GRANT[3].valid === 1'b0, "fetch unpowered slice");
      apb(1'b1, 12'h000, 32'h0000_0005);
      settle();
      @(posedge CLK) FETCH_REQ <= 4'h8;
      @(posedge CLK);
      #1;
      chk(FETCH_GRANT[3].valid === 1'b1 && FETCH_GRANT[3].blk === 11'h7F0 && FETCH_GRANT[3].line === 3'h0,
         "fetch slice two");
      @(posedge CLK) FETCH_REQ <= 4'h0;
   endtask : t_share
   task stop_test();
      $display("errors %0d checks %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test
   // Ceiling well above the few hundred cycles the run needs
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         stop_test();
      end
   end
   initial begin
      repeat (16) @(posedge CLK);
      @(posedge CLK) RST_N <= 1'b1;
      t_reset();
      t_range();
      t_atomic();
      t_fetch();
      t_hdr();
      t_cursor();
      t_share();
      stop_test();
   end
endmodule : tb_display_buffer_allocation
